// >>> dv/tb_wdtc_top.sv
`timescale 1ns/1ps
module tb_wdtc_top;
  logic        mclk_in = 1'b0, nrst_in = 1'b0;
  logic        sub_clk_in = 1'b0, interval_ovf_out;
  logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic        avs_waitrequest_out, nmi_req_out, rst_req_out;
  int          bad_count = 0, num_checks = 0;
  wire [2:0]   ev = {nmi_req_out, rst_req_out, interval_ovf_out};
  wdtc_top wdtc_top_inst (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .sub_clk_in(sub_clk_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .nmi_req_out(nmi_req_out),
    .rst_req_out(rst_req_out), .interval_ovf_out(interval_ovf_out));
  always #2.5 mclk_in = ~mclk_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // request stands until waitrequest is sampled low at an edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    {avs_address_in, avs_writedata_in} <= {a, d};
    {avs_write_in, avs_read_in} <= {w, !w};
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge mclk_in);
    q = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
    @(posedge mclk_in);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task t_stop;
    bus(1'b1, 4'h0, 32'h20);
    repeat (40) @(posedge mclk_in);
    bus(1'b0, 4'h4, 32'h0);
    chk(q[7:0] != 8'h00, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h1, 32'hFF);
    rd(4'h1, 32'h0);
    rd(4'hC, 32'h00010001);
    bus(1'b1, 4'h0, 32'h30);
    // six settled subclock rises at ratio 1 give three count steps
    repeat (12) begin
      repeat (4) @(posedge mclk_in);
      sub_clk_in <= ~sub_clk_in;
    end
    repeat (8) @(posedge mclk_in);
    rd(4'h4, 32'h3);
    bus(1'b1, 4'h0, 32'h10);
    rd(4'h4, 32'h3);
    bus(1'b1, 4'h4, 32'h0);
    rd(4'h4, 32'h0);
  endtask
  task t_ovf(input logic [31:0] c, input logic [2:0] e);
    logic [2:0] seen;
    seen = 3'h0;
    bus(1'b1, 4'h4, 32'hFE);
    bus(1'b1, 4'h0, c);
    repeat (20) @(posedge mclk_in) seen = seen | ev;
    chk(seen, e);
    rd(4'h8, {30'h0, e[1], e[2]});
    bus(1'b1, 4'h8, 32'h3);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
  endtask
  task conclude;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // three reset cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_stop;
    t_ovf(32'h60, 3'h4);
    t_ovf(32'h68, 3'h2);
    t_ovf(32'h20, 3'h1);
    conclude;
  end
  initial begin
    #20000 bad_count++; // scenarios need far fewer cycles than this
    conclude;
  end
endmodule

// >>> dv/wdtc_monitor.sv
`timescale 1ns/1ps
module wdtc_monitor (
  input wire        mclk_in,
  input wire        nrst_in,
  input wire [3:0]  avs_address_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire        avs_waitrequest_out,
  input wire        nmi_req_out,
  input wire        rst_req_out,
  input wire        interval_ovf_out
);
  logic [3:0] ctrl; // mode, run, source, action
  wire        ev = nmi_req_out | rst_req_out | interval_ovf_out;
  always @(posedge mclk_in or negedge nrst_in) // stalled writes do not count
    if (!nrst_in)
      ctrl <= 4'h0;
    else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0)
      ctrl <= avs_writedata_in[6:3];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req; $rose(avs_write_in); endsequence
  sequence s_halted; !ctrl[2] [*3]; endsequence
  a_bus_answer: assert property (s_req |=> !avs_waitrequest_out)
    else $error("late answer");
  a_halt_quiet: assert property (s_halted |-> !ev)
    else $error("event while stopped");
  a_nmi_mode: assert property (nmi_req_out |-> ctrl[3] && !ctrl[0])
    else $error("stray nmi");
  a_rst_mode: assert property (rst_req_out |-> ctrl[3] && ctrl[0])
    else $error("stray reset");
  a_ival_mode: assert property (interval_ovf_out |-> !ctrl[3])
    else $error("stray interval");
  a_nmi_pulse: assert property (nmi_req_out |=> !nmi_req_out)
    else $error("long nmi");
  a_rst_pulse: assert property (rst_req_out |=> !rst_req_out)
    else $error("long reset");
endmodule
bind wdtc_top wdtc_monitor wdtc_monitor_inst (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out), .nmi_req_out(nmi_req_out),
  .rst_req_out(rst_req_out), .interval_ovf_out(interval_ovf_out));

// >>> verilog/wdtc_div.v
`timescale 1ns/1ps
// =====================================================================
// divider: one-cycle enable every (ratio+1) clocks while active
module wdtc_div #(
  parameter W = 16
) (
  input  wire         mclk_in,
  input  wire         nrst_in,
  input  wire         run_in,
  input  wire [W-1:0] ratio_in,
  output reg          tick_out
);
  reg [W-1:0] cnt;

  // stopped divider restarts from zero so the first tick is a full period
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt      <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt      <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (cnt >= ratio_in) begin
      cnt      <= {W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      cnt      <= cnt + {{(W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end
endmodule

// >>> verilog/wdtc_map.vh
`ifndef WDTC_MAP_VH
`define WDTC_MAP_VH
// =====================================================================
// register offsets (byte addresses, one 32-bit word each)
`define WDTC_OFF_CTRL       4'h0
`define WDTC_OFF_COUNT      4'h4
`define WDTC_OFF_STATUS     4'h8
`define WDTC_OFF_DIV        4'hC
// =====================================================================
// control field positions
`define WDTC_BIT_ACTION     3
`define WDTC_BIT_SRC        4
`define WDTC_BIT_RUN        5
`define WDTC_BIT_MODE       6
// status field positions
`define WDTC_BIT_OVF_NMI    0
`define WDTC_BIT_OVF_RST    1
// =====================================================================
// reset values and defaults
`define WDTC_CTRL_RST       8'h00
`define WDTC_COUNT_RST      8'h00
`define WDTC_MAIN_DIV_RST   16'h0001
`define WDTC_SUB_DIV_RST    16'h0001
`endif

// >>> verilog/wdtc_top.v
`timescale 1ns/1ps
`include "wdtc_map.vh"
module wdtc_top #(
  parameter DIV_W = 16
) (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire        sub_clk_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output reg         nmi_req_out,
  output reg         rst_req_out,
  output reg         interval_ovf_out
);
  // ===================================================================
  // registers
  // control fields mirror the written control byte; the count is the
  // only timer state that software may also load directly
  reg             timer_mode_select;
  reg             counter_run_enable;
  reg             clock_source_select;
  reg             overflow_action;
  reg [7:0]       count_register;
  reg             sticky_nmi;
  reg             sticky_rst;
  reg [DIV_W-1:0] main_div;
  reg [DIV_W-1:0] sub_div;
  reg             ack;
  reg [2:0]       sub_sync;
  reg             sub_prev;
  wire            main_tick;
  wire            sub_edge;
  wire            wr;
  wire            rd;
  wire            cnt_tick;

  // ===================================================================
  // subclock pin: three flops, a change counts once stages two and
  // three agree; sub_edge is a rising edge of the settled level
  // limitation: each subclock level must hold for at least two mclk
  // cycles, or its edge is lost in the synchroniser
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sub_sync <= 3'h0;
      sub_prev <= 1'b0;
    end else begin
      sub_sync <= {sub_sync[1:0], sub_clk_in};
      if (sub_sync[2] == sub_sync[1])
        sub_prev <= sub_sync[2];
    end
  end
  assign sub_edge = (sub_sync[2] == sub_sync[1]) && sub_sync[2] && !sub_prev;

  // ===================================================================
  // main-clock prescaler as a divider enable
  // a ratio of n gives one tick every n+1 clocks, so ratio 0 ticks on
  // every clock; the divider idles while the sub source is chosen
  wdtc_div #(.W(DIV_W)) u_main_div (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .run_in   (counter_run_enable & ~clock_source_select),
    .ratio_in (main_div),
    .tick_out (main_tick)
  );

  // subclock prescaler: divide settled subclock edges by sub_div+1
  // kept on mclk rather than clocked by the pin, so the counter sees a
  // single clock domain and no word crosses between domains
  reg [DIV_W-1:0] sub_cnt;
  reg             sub_tick;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sub_cnt  <= {DIV_W{1'b0}};
      sub_tick <= 1'b0;
    end else begin
      sub_tick <= 1'b0;
      if (!(counter_run_enable && clock_source_select))
        sub_cnt <= {DIV_W{1'b0}};
      else if (sub_edge) begin
        if (sub_cnt >= sub_div) begin
          sub_cnt  <= {DIV_W{1'b0}};
          sub_tick <= 1'b1;
        end else
          sub_cnt <= sub_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // source choice feeds the counter
  // the unselected prescaler is held in reset, so a switch starts clean
  assign cnt_tick = clock_source_select ? sub_tick : main_tick;

  // ===================================================================
  // bus handshake: one wait cycle, then a single acknowledge cycle
  // trade-off: one wait state on every access buys registered read
  // data and a write that lands only at the accepting edge
  assign wr = avs_write_in && ack;
  assign rd = avs_read_in && ack;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack                 <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack                 <= (avs_read_in | avs_write_in) & ~ack;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack);
    end
  end

  // read data registered alongside the acknowledge
  // unmapped offsets read as zero; the value holds until the next read
  // so a slow master still sees it after the accepting edge
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in)
      avs_readdata_out <= 32'h00000000;
    else if (avs_read_in && !ack) begin
      case (avs_address_in)
        `WDTC_OFF_CTRL:
          avs_readdata_out <= {25'h0000000, timer_mode_select,
                               counter_run_enable, clock_source_select,
                               overflow_action, 3'h0};
        `WDTC_OFF_COUNT:  avs_readdata_out <= {24'h000000, count_register};
        `WDTC_OFF_STATUS: avs_readdata_out <= {30'h00000000, sticky_rst,
                                               sticky_nmi};
        `WDTC_OFF_DIV:    avs_readdata_out <= {sub_div, main_div};
        default:          avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // ===================================================================
  // control fields, divider ratios
  // only byte lane 0 carries control bits; writes to other lanes of
  // the control word are ignored, unmapped writes change nothing
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_mode_select   <= 1'b0;
      counter_run_enable  <= 1'b0;
      clock_source_select <= 1'b0;
      overflow_action     <= 1'b0;
      main_div            <= `WDTC_MAIN_DIV_RST;
      sub_div             <= `WDTC_SUB_DIV_RST;
    end else if (wr) begin
      if (avs_address_in == `WDTC_OFF_CTRL && avs_byteenable_in[0]) begin
        timer_mode_select   <= avs_writedata_in[`WDTC_BIT_MODE];
        counter_run_enable  <= avs_writedata_in[`WDTC_BIT_RUN];
        clock_source_select <= avs_writedata_in[`WDTC_BIT_SRC];
        overflow_action     <= avs_writedata_in[`WDTC_BIT_ACTION];
      end
      if (avs_address_in == `WDTC_OFF_DIV) begin
        if (avs_byteenable_in[0]) main_div[7:0]  <= avs_writedata_in[7:0];
        if (avs_byteenable_in[1]) main_div[15:8] <= avs_writedata_in[15:8];
        if (avs_byteenable_in[2]) sub_div[7:0]   <= avs_writedata_in[23:16];
        if (avs_byteenable_in[3]) sub_div[15:8]  <= avs_writedata_in[31:24];
      end
    end
  end

  // ===================================================================
  // counter: a direct write wins over a tick in the same cycle
  // zeroing on a stop follows the source bit written with the stop, so
  // one write can halt the subclock count and keep its value
  wire ctrl_wr = wr && avs_address_in == `WDTC_OFF_CTRL &&
                 avs_byteenable_in[0];
  wire run_clr = ctrl_wr && !avs_writedata_in[`WDTC_BIT_RUN];
  wire ovf     = counter_run_enable && cnt_tick && count_register == 8'hFF;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in)
      count_register <= `WDTC_COUNT_RST;
    else if (wr && avs_address_in == `WDTC_OFF_COUNT && avs_byteenable_in[0])
      count_register <= avs_writedata_in[7:0];
    else if (run_clr && !avs_writedata_in[`WDTC_BIT_SRC])
      count_register <= 8'h00;
    else if (run_clr)
      count_register <= count_register;
    else if (counter_run_enable && cnt_tick)
      count_register <= count_register + 8'h01;
  end

  // ===================================================================
  // overflow: watchdog mode routes to nmi or reset; interval mode only
  // pulses its own flag; sticky status set wins over a clear write
  // interval mode never requests nmi or reset, so an interval overflow
  // cannot take the system down
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_req_out      <= 1'b0;
      rst_req_out      <= 1'b0;
      interval_ovf_out <= 1'b0;
      sticky_nmi       <= 1'b0;
      sticky_rst       <= 1'b0;
    end else begin
      nmi_req_out      <= ovf && timer_mode_select && !overflow_action;
      rst_req_out      <= ovf && timer_mode_select && overflow_action;
      interval_ovf_out <= ovf && !timer_mode_select;
      if (ovf && timer_mode_select && !overflow_action)
        sticky_nmi <= 1'b1;
      else if (wr && avs_address_in == `WDTC_OFF_STATUS &&
               avs_writedata_in[`WDTC_BIT_OVF_NMI])
        sticky_nmi <= 1'b0;
      if (ovf && timer_mode_select && overflow_action)
        sticky_rst <= 1'b1;
      else if (wr && avs_address_in == `WDTC_OFF_STATUS &&
               avs_writedata_in[`WDTC_BIT_OVF_RST])
        sticky_rst <= 1'b0;
    end
  end
endmodule
